/* File: core/dual_clock_fifo.sv */
// Dual-clock FIFO with status flags and optional lookahead output
//
// Overview of operation
// R1 - Write while not full stores the word
// R2 - Filling the last location raises full next
// R3 - Write while full dropped, overflow next cycle
// R4 - Read while not empty pops oldest word
// R5 - Reading the last word raises empty next
// R6 - Read while empty changes nothing, flags underflow
// R7 - Each flag generated in its own domain
// R8 - Near-drained when count at or below margin
// R9 - Near-capacity when free at or below margin
// R10 - Pointers cross domains through synchronising registers
// R11 - Full flags assert at once, clear later
// R12 - Empty flags assert at once, clear later
// R13 - Flags use local and synchronised remote pointers
// R14 - Lookahead register self-loads, first word falls through
// R15 - Lookahead full flags clear on first transfer
// R16 - Lookahead near-capacity counts storage space only
// R17 - Lookahead empty tracks output register occupancy
// R18 - Lookahead near-drained counts storage words only
// R19 - Consumer sets low margin one below threshold
// R20 - Producer withholds writes while full
// R21 - Reset held four slow cycles empties FIFO
// R22 - Bypass skips synchronisers for shared clocks
// R23 - Lookahead only with synchroniser bypass cleared
// R24 - Reset leaves empty flags set, others clear
`timescale 1ns/1ps
`include "fifo_cfg.svh"

module dual_clock_fifo
   import fifo_pkg::*;
#(
   parameter int DATA_W = `FIFO_DATA_W,
   parameter int ADDR_W = `FIFO_ADDR_W,
   parameter logic [7:0] AFULL_OFFSET = `FIFO_AFULL_OFFSET,
   parameter logic [7:0] AEMPTY_OFFSET = `FIFO_AEMPTY_OFFSET,
   parameter bit PTR_SYNC_MODE = `FIFO_PTR_SYNC_MODE,
   parameter bit FWFT_MODE = `FIFO_FWFT_MODE
)
(
   // Write side
   input wire logic wr_clk,
   input wire logic wr_en,
   input wire logic [DATA_W-1:0] wr_data,
   output wr_flags_s wr_flags,
   // Read side
   input wire logic rd_clk,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   output rd_flags_s rd_flags,
   // Reset
   input wire logic rst_b
);

   // ==================================================================
   // Sizing
   localparam int CNT_W = ADDR_W + 1;
   localparam logic [CNT_W-1:0] DEPTH = CNT_W'(1 << ADDR_W);
   localparam logic [CNT_W-1:0] AFULL_TH = CNT_W'(AFULL_OFFSET);
   // Lookahead near-drained excludes the output register
   localparam logic [CNT_W-1:0] AEMPTY_TH =
      CNT_W'(int'(AEMPTY_OFFSET) + (FWFT_MODE ? 0 : 1)); // [R8] [R18]

   // Gray helpers; only gray words cross domains, one bit moves at a time
   function automatic logic [CNT_W-1:0] bin2gray(
      input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [CNT_W-1:0] gray2bin(
      input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b[CNT_W-1] = g[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction

   // ==================================================================
   // Reset release, synchronised per domain
   logic wr_rst_b;
   logic rd_rst_b;

   // Assertion is immediate; release waits two edges of each clock
   sync_chain #(.W(1)) u_wr_rst (
      .clk(wr_clk),
      .rst_b(rst_b),
      .d(1'b1),
      .q(wr_rst_b)
   ); // [R21]

   sync_chain #(.W(1)) u_rd_rst (
      .clk(rd_clk),
      .rst_b(rst_b),
      .d(1'b1),
      .q(rd_rst_b)
   ); // [R21]

   // ==================================================================
   // Pointer state
   logic [CNT_W-1:0] wptr_reg;
   logic [CNT_W-1:0] wptr_next;
   logic [CNT_W-1:0] wgray_reg;
   logic [CNT_W-1:0] rptr_reg;
   logic [CNT_W-1:0] rptr_next;
   logic [CNT_W-1:0] rgray_reg;
   logic [CNT_W-1:0] wgray_sync;
   logic [CNT_W-1:0] rgray_sync;

   // ==================================================================
   // Domain crossing
   generate
      if (PTR_SYNC_MODE)
      begin : g_bypass
         // Shared clock: registered pointer is already safe to read
         assign wgray_sync = wgray_reg; // [R22]
         assign rgray_sync = rgray_reg; // [R22]
      end
      else
      begin : g_sync
         sync_chain #(.W(CNT_W)) u_w2r (
            .clk(rd_clk),
            .rst_b(rd_rst_b),
            .d(wgray_reg),
            .q(wgray_sync)
         ); // [R10]

         sync_chain #(.W(CNT_W)) u_r2w (
            .clk(wr_clk),
            .rst_b(wr_rst_b),
            .d(rgray_reg),
            .q(rgray_sync)
         ); // [R10]
      end
   endgenerate

   // ==================================================================
   // Write domain
   logic wr_do;
   logic [CNT_W-1:0] rptr_wd;
   logic [CNT_W-1:0] wcount;
   logic [CNT_W-1:0] wcount_next;
   logic [CNT_W-1:0] wfree_next;

   // Writes while full are dropped; producer should not issue them
   assign wr_do = wr_en && !wr_flags.full; // [R1] [R3] [R20]
   assign wptr_next = wptr_reg + CNT_W'(wr_do);
   assign rptr_wd = gray2bin(rgray_sync); // [R13]
   assign wcount = wptr_reg - rptr_wd;
   assign wcount_next = wptr_next - rptr_wd; // [R13]
   assign wfree_next = DEPTH - wcount_next;

   // Write pointer, binary and gray
   always_ff @(posedge wr_clk or negedge wr_rst_b)
   begin
      if (!wr_rst_b)
      begin
         wptr_reg <= '0;
         wgray_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_next;
         wgray_reg <= bin2gray(wptr_next);
      end
   end

   // Flags from the new local pointer: set at once, clear lags sync
   always_ff @(posedge wr_clk or negedge wr_rst_b)
   begin
      if (!wr_rst_b)
      begin
         wr_flags.full <= `FIFO_FULL_RST; // [R24]
         wr_flags.almost_full <= `FIFO_AFULL_RST; // [R24]
         wr_flags.overflow <= `FIFO_ERR_RST; // [R24]
      end
      else
      begin
         wr_flags.full <= (wcount_next == DEPTH); // [R2] [R7] [R11]
         wr_flags.almost_full <= (wfree_next <= AFULL_TH); // [R9] [R16]
         wr_flags.overflow <= wr_en && wr_flags.full; // [R3]
      end
   end

   // ==================================================================
   // Storage
   logic pop;

   // Storage read register doubles as the lookahead output register
   fifo_ram #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_ram (
      .wr_clk(wr_clk),
      .wr_en(wr_do),
      .wr_addr(wptr_reg[ADDR_W-1:0]),
      .wr_data(wr_data),
      .rd_clk(rd_clk),
      .rd_rst_b(rd_rst_b),
      .rd_en(pop),
      .rd_addr(rptr_reg[ADDR_W-1:0]),
      .rd_data(rd_data)
   ); // [R1] [R4]

   // ==================================================================
   // Read domain
   logic [CNT_W-1:0] wptr_rd;
   logic [CNT_W-1:0] rcount;
   logic [CNT_W-1:0] rcount_next;
   logic mem_avail;
   logic out_valid_reg;
   logic out_valid_next;

   assign wptr_rd = gray2bin(wgray_sync); // [R13]
   assign rcount = wptr_rd - rptr_reg;
   assign mem_avail = (rcount != '0);

   // Pop decision; lookahead refills whenever the output is free
   always_comb
   begin
      if (FWFT_MODE)
         pop = mem_avail && (!out_valid_reg || rd_en); // [R14] [R15]
      else
         pop = rd_en && !rd_flags.empty; // [R4] [R6]
   end

   assign rptr_next = rptr_reg + CNT_W'(pop); // [R4]
   assign rcount_next = wptr_rd - rptr_next; // [R13]
   assign out_valid_next = pop || (out_valid_reg && !rd_en);

   // Read pointer, binary and gray
   always_ff @(posedge rd_clk or negedge rd_rst_b)
   begin
      if (!rd_rst_b)
      begin
         rptr_reg <= '0;
         rgray_reg <= '0;
      end
      else
      begin
         rptr_reg <= rptr_next;
         rgray_reg <= bin2gray(rptr_next);
      end
   end

   // Output register occupancy, only meaningful in lookahead mode
   always_ff @(posedge rd_clk or negedge rd_rst_b)
   begin
      if (!rd_rst_b)
         out_valid_reg <= 1'b0;
      else
         out_valid_reg <= FWFT_MODE && out_valid_next; // [R17]
   end

   // Flags from the new local pointer: set at once, clear lags sync
   always_ff @(posedge rd_clk or negedge rd_rst_b)
   begin
      if (!rd_rst_b)
      begin
         rd_flags.empty <= `FIFO_EMPTY_RST; // [R24]
         rd_flags.almost_empty <= `FIFO_AEMPTY_RST; // [R24]
         rd_flags.underflow <= `FIFO_ERR_RST; // [R24]
      end
      else
      begin
         if (FWFT_MODE)
            rd_flags.empty <= !out_valid_next; // [R17]
         else
            rd_flags.empty <= (rcount_next == '0); // [R5] [R7] [R12]
         rd_flags.almost_empty <= (rcount_next < AEMPTY_TH); // [R8] [R18]
         rd_flags.underflow <= rd_en && rd_flags.empty; // [R6]
      end
   end

   // ==================================================================
   // Assertions, write domain
   full_level_a: assert property (@(posedge wr_clk) disable iff (!wr_rst_b)
      (wcount == DEPTH) |-> wr_flags.full) // [R2]
      else $error("full low while storage holds depth words");

   full_next_a: assert property (@(posedge wr_clk) disable iff (!wr_rst_b)
      (wr_do && wcount == DEPTH - 1) |=> wr_flags.full) // [R11]
      else $error("full not raised after last free slot written");

   afull_level_a: assert property (@(posedge wr_clk)
      disable iff (!wr_rst_b)
      ((DEPTH - wcount) <= AFULL_TH) |-> wr_flags.almost_full) // [R9]
      else $error("almost_full low with few free locations");

   overflow_drop_a: assert property (@(posedge wr_clk)
      disable iff (!wr_rst_b)
      (wr_en && wr_flags.full) |=>
         (wr_flags.overflow && $stable(wptr_reg))) // [R3]
      else $error("write while full not dropped or not flagged");

   overflow_only_a: assert property (@(posedge wr_clk)
      disable iff (!wr_rst_b)
      !(wr_en && wr_flags.full) |=> !wr_flags.overflow) // [R3]
      else $error("overflow raised without a write while full");

   // ==================================================================
   // Assertions, read domain
   underflow_hold_a: assert property (@(posedge rd_clk)
      disable iff (!rd_rst_b)
      (rd_en && rd_flags.empty) |=>
         (rd_flags.underflow && $stable(rd_data))) // [R6]
      else $error("read while empty changed data or not flagged");

   empty_next_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_b)
      (!FWFT_MODE && pop && rcount == 1) |=> rd_flags.empty) // [R5]
      else $error("empty not raised after last word read");

   aempty_level_a: assert property (@(posedge rd_clk)
      disable iff (!rd_rst_b)
      (rcount < AEMPTY_TH) |-> rd_flags.almost_empty) // [R8]
      else $error("almost_empty low with few stored words");

   first_fall_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_b)
      (FWFT_MODE && rd_flags.empty && mem_avail) |=>
         !rd_flags.empty ##0 $changed(rptr_reg)) // [R14]
      else $error("lookahead register did not load a waiting word");

   // ==================================================================
   // Scenario covers
   reach_full_c: cover property (@(posedge wr_clk) disable iff (!wr_rst_b)
      wr_flags.full ##1 !wr_flags.full);

   overflow_c: cover property (@(posedge wr_clk) disable iff (!wr_rst_b)
      wr_flags.overflow);

   underflow_c: cover property (@(posedge rd_clk) disable iff (!rd_rst_b)
      rd_flags.underflow);

   drain_c: cover property (@(posedge rd_clk) disable iff (!rd_rst_b)
      !rd_flags.almost_empty ##[1:300] rd_flags.empty);

endmodule

/* File: core/fifo_cfg.svh */
// Default configuration constants for the dual-clock FIFO
`ifndef FIFO_CFG_SVH
`define FIFO_CFG_SVH

// =====================================================================
// Geometry
`define FIFO_DATA_W 16
`define FIFO_ADDR_W 7

// =====================================================================
// Status thresholds
`define FIFO_AFULL_OFFSET 8'h04
`define FIFO_AEMPTY_OFFSET 8'h04

// =====================================================================
// Mode selects
`define FIFO_PTR_SYNC_MODE 1'b0
`define FIFO_FWFT_MODE 1'b0

// =====================================================================
// Reset values of the status flags
`define FIFO_EMPTY_RST 1'b1
`define FIFO_AEMPTY_RST 1'b1
`define FIFO_FULL_RST 1'b0
`define FIFO_AFULL_RST 1'b0
`define FIFO_ERR_RST 1'b0

`endif

/* File: core/fifo_pkg.sv */
// Types shared by the dual-clock FIFO design files
package fifo_pkg;

   // ==================================================================
   // Status carriers, one per clock domain
   typedef struct packed {
      logic full;
      logic almost_full;
      logic overflow;
   } wr_flags_s;

   typedef struct packed {
      logic empty;
      logic almost_empty;
      logic underflow;
   } rd_flags_s;

endpackage

/* File: core/sync_chain.sv */
// Two-flop synchroniser for a level or a gray-coded word
`timescale 1ns/1ps

module sync_chain
#(
   parameter int W = 1
)
(
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Crossing word
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // ==================================================================
   // Chain
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

/* File: core/fifo_ram.sv */
// Storage array with a write port and a registered read port
`timescale 1ns/1ps

module fifo_ram
#(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 7
)
(
   // Write port
   input wire logic wr_clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   // Read port
   input wire logic rd_clk,
   input wire logic rd_rst_b,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data
);

   // ==================================================================
   // Array
   logic [DATA_W-1:0] mem [2**ADDR_W];

   // Contents are not reset; pointers alone define what is valid
   always_ff @(posedge wr_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   // Output holds its value until the next pop
   always_ff @(posedge rd_clk or negedge rd_rst_b)
   begin
      if (!rd_rst_b)
         rd_data <= '0;
      else if (rd_en)
         rd_data <= mem[rd_addr];
   end

endmodule

/* File: verification/fifo_user_model.sv */
// Producer and consumer logic standing at the FIFO user ports
`timescale 1ns/1ps

module fifo_user_model
   import fifo_pkg::*;
#(
   parameter int DATA_W = 16
)
(
   // Commands from the bench
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic cmd_force,
   input wire logic [DATA_W-1:0] cmd_data,
   // Status seen by the user logic
   input wire wr_flags_s wr_flags,
   input wire rd_flags_s rd_flags,
   // Requests towards the FIFO
   output logic wr_en,
   output logic [DATA_W-1:0] wr_data,
   output logic rd_en
);
   // ==================================================================
   // Request gating
   logic [DATA_W-1:0] last_data;

   // Honest producer holds writes back while full; force breaks it
   assign wr_en = cmd_wr & (cmd_force | ~wr_flags.full);
   // Honest consumer holds reads back while empty
   assign rd_en = cmd_rd & (cmd_force | ~rd_flags.empty);
   // Idle data shows the inverse, so stale words never look valid
   assign wr_data = cmd_wr ? cmd_data : ~last_data;

   // Remember the last word offered
   initial last_data = '0;
   always @*
      if (cmd_wr)
         last_data = cmd_data;
endmodule

/* File: verification/test_dual_clock_fifo.sv */
// Self-checking bench for the dual-clock FIFO in one clock domain
`timescale 1ns/1ps

module test_dual_clock_fifo
   import fifo_pkg::*;
;
   // ==================================================================
   // Signals
   localparam int DW = 16;
   localparam int DEPTH = 128;
   localparam int AF = 4;
   localparam int AE = 4;
   // Lookahead copy drains below four words, so its margin is three
   localparam int FAE = 3;
   logic clk, rst_b, cmd_wr, cmd_rd, cmd_force, wr_en_w, rd_en_w;
   logic [DW-1:0] cmd_data, wr_data_w, rd_data, last_rd;
   wr_flags_s wr_flags;
   rd_flags_s rd_flags;
   logic fcmd_wr, fcmd_rd, fcmd_force, fwr_en, frd_en;
   logic [DW-1:0] fwr_data, frd_data, brd_data;
   wr_flags_s fwr_flags, bwr_flags;
   rd_flags_s frd_flags, brd_flags;
   int miscompares = 0;
   int tests_run = 0;
   int stored = 0;
   int sizes[6] = '{1, 4, 5, 128, 0, 0};
   logic [DW-1:0] sent[$];

   // Both ports share one clock: only one clock exists here
   dual_clock_fifo #(.DATA_W(DW), .ADDR_W(7)) dut_u (
      .wr_clk(clk), .wr_en(wr_en_w), .wr_data(wr_data_w),
      .wr_flags(wr_flags), .rd_clk(clk), .rd_en(rd_en_w),
      .rd_data(rd_data), .rd_flags(rd_flags), .rst_b(rst_b));

   fifo_user_model #(.DATA_W(DW)) model_u (
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_force(cmd_force),
      .cmd_data(cmd_data), .wr_flags(wr_flags), .rd_flags(rd_flags),
      .wr_en(wr_en_w), .wr_data(wr_data_w), .rd_en(rd_en_w));

   // Bypass copy runs in lockstep; its empty flag clears sooner
   dual_clock_fifo #(.DATA_W(DW), .ADDR_W(7), .PTR_SYNC_MODE(1'b1)) byp_u (
      .wr_clk(clk), .wr_en(wr_en_w), .wr_data(wr_data_w),
      .wr_flags(bwr_flags), .rd_clk(clk), .rd_en(rd_en_w),
      .rd_data(brd_data), .rd_flags(brd_flags), .rst_b(rst_b));

   // Lookahead copy with its own user logic; synchronisers must stay on
   dual_clock_fifo #(.DATA_W(DW), .ADDR_W(7), .AEMPTY_OFFSET(8'h03),
      .PTR_SYNC_MODE(1'b0), .FWFT_MODE(1'b1)) fwft_u (
      .wr_clk(clk), .wr_en(fwr_en), .wr_data(fwr_data),
      .wr_flags(fwr_flags), .rd_clk(clk), .rd_en(frd_en),
      .rd_data(frd_data), .rd_flags(frd_flags), .rst_b(rst_b));

   fifo_user_model #(.DATA_W(DW)) fmodel_u (
      .cmd_wr(fcmd_wr), .cmd_rd(fcmd_rd), .cmd_force(fcmd_force),
      .cmd_data(cmd_data), .wr_flags(fwr_flags), .rd_flags(frd_flags),
      .wr_en(fwr_en), .wr_data(fwr_data), .rd_en(frd_en));

   // 200 MHz clock
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // ==================================================================
   // Compare and verdict tasks
   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_word(input string what, input logic [DW-1:0] exp,
                             input logic [DW-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==================================================================
   // Cycle driver: entered just after an edge, leaves just after the next
   task automatic step(input logic w, input logic r, input logic f);
      logic popped;
      logic [DW-1:0] exp;
      popped = 1'b0;
      cmd_wr = w;
      cmd_rd = r;
      cmd_force = f;
      cmd_data = DW'($urandom);
      if (w && stored < DEPTH)
      begin
         sent.push_back(cmd_data);
         stored++;
      end
      if (r && stored > 0)
      begin
         exp = sent.pop_front();
         stored--;
         popped = 1'b1;
      end
      @(posedge clk);
      #1;
      if (popped)
      begin
         check_word("rd_data", exp, rd_data);
         check_word("bypass rd_data", exp, brd_data);
         last_rd = exp;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) step(1'b0, 1'b0, 1'b0);
   endtask

   // ==================================================================
   // Expected flag levels for a given number of stored words
   function automatic logic af_exp(input int words);
      return (DEPTH - words) <= AF;
   endfunction

   function automatic logic ae_exp(input int words);
      return words <= AE;
   endfunction

   // Flag values expected straight after any reset
   task automatic check_reset_flags();
      check_bit("empty", 1'b1, rd_flags.empty);
      check_bit("almost_empty", 1'b1, rd_flags.almost_empty);
      check_bit("underflow", 1'b0, rd_flags.underflow);
      check_bit("full", 1'b0, wr_flags.full);
      check_bit("almost_full", 1'b0, wr_flags.almost_full);
      check_bit("overflow", 1'b0, wr_flags.overflow);
   endtask

   // Fill with n words, drain them all, then read once too many
   task automatic run_round(input int n);
      for (int k = 1; k <= n; k++)
      begin
         step(1'b1, 1'b0, 1'b0);
         check_bit("almost_full", af_exp(k), wr_flags.almost_full);
         check_bit("full", k == DEPTH, wr_flags.full);
      end
      if (n == DEPTH)
      begin
         step(1'b1, 1'b0, 1'b1);
         check_bit("overflow", 1'b1, wr_flags.overflow);
         check_bit("full", 1'b1, wr_flags.full);
         check_bit("bypass full", 1'b1, bwr_flags.full);
         idle(1);
         check_bit("overflow", 1'b0, wr_flags.overflow);
      end
      // Bypass sees the write pointer one edge later, no synchroniser
      idle(1);
      check_bit("bypass empty", 1'b0, brd_flags.empty);
      // Write pointer needs a few edges to reach the read side
      idle(5);
      check_bit("empty", 1'b0, rd_flags.empty);
      check_bit("almost_empty", ae_exp(n), rd_flags.almost_empty);
      for (int k = n - 1; k >= 0; k--)
      begin
         step(1'b0, 1'b1, 1'b0);
         check_bit("almost_empty", ae_exp(k), rd_flags.almost_empty);
         check_bit("empty", k == 0, rd_flags.empty);
      end
      step(1'b0, 1'b1, 1'b1);
      check_bit("underflow", 1'b1, rd_flags.underflow);
      check_word("rd_data", last_rd, rd_data);
      idle(6);
      check_bit("underflow", 1'b0, rd_flags.underflow);
      check_bit("full", 1'b0, wr_flags.full);
      check_bit("almost_full", 1'b0, wr_flags.almost_full);
   endtask

   // Lookahead copy: the first word shows up without any read
   task automatic fwft_round(input int n);
      logic [DW-1:0] q[$];
      for (int k = 0; k < n; k++)
      begin
         fcmd_wr = 1'b1;
         cmd_data = DW'($urandom);
         q.push_back(cmd_data);
         @(posedge clk);
         #1;
      end
      fcmd_wr = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check_bit("lookahead empty", 1'b0, frd_flags.empty);
      check_word("lookahead rd_data", q[0], frd_data);
      check_bit("lookahead almost_empty", n - 1 < FAE,
                frd_flags.almost_empty);
      check_bit("lookahead almost_full", 1'b0,
                fwr_flags.almost_full);
      for (int j = 1; j <= n; j++)
      begin
         fcmd_rd = 1'b1;
         @(posedge clk);
         #1;
         check_word("lookahead rd_data", q[(j < n) ? j : n - 1],
                    frd_data);
         check_bit("lookahead empty", j == n, frd_flags.empty);
         check_bit("lookahead almost_empty", n - 1 - j < FAE,
                   frd_flags.almost_empty);
      end
      fcmd_force = 1'b1;
      @(posedge clk);
      #1;
      fcmd_rd = 1'b0;
      fcmd_force = 1'b0;
      check_bit("lookahead underflow", 1'b1, frd_flags.underflow);
      check_word("lookahead rd_data", q[n - 1], frd_data);
   endtask

   // ==================================================================
   // Main sequence
   initial
   begin
      void'($urandom(35066));
      rst_b = 1'b0;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_force = 1'b0;
      cmd_data = '0;
      fcmd_wr = 1'b0;
      fcmd_rd = 1'b0;
      fcmd_force = 1'b0;
      last_rd = '0;
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      idle(3);
      check_reset_flags();
      // Two random depths join the boundary ones
      sizes[4] = 1 + ($urandom % (DEPTH - 1));
      sizes[5] = 1 + ($urandom % (DEPTH - 1));
      foreach (sizes[i])
         run_round(sizes[i]);
      // Lookahead copy: a lone word, then a short random burst
      fwft_round(1);
      fwft_round(2 + $urandom % 6);
      // Reset with words stored must discard them all
      repeat (10) step(1'b1, 1'b0, 1'b0);
      cmd_wr = 1'b0;
      rst_b = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      sent.delete();
      stored = 0;
      last_rd = '0;
      idle(3);
      check_reset_flags();
      step(1'b0, 1'b1, 1'b1);
      check_bit("underflow", 1'b1, rd_flags.underflow);
      check_word("rd_data", last_rd, rd_data);
      complete_run();
   end

   // Whole run is under a thousand cycles; this span is far beyond it
   initial
   begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule
